// ### ists_top.sv
// Two-wire bus slave transmit path: address, acknowledge, stretching, byte output
// Notes on behaviour
// - Matched read address sets status read bit.
// - Matched read address byte lands in buffer.
// - Acknowledge address, clear release bit, hold clock.
// - Buffer write loads shift register for output.
// - Release bit set frees the clock line.
// - Data bits change on clock falling edges.
// - Interrupt flag set at ninth falling edge.
// - Master acknowledge sampled on ninth rising edge.
// - Not acknowledged: reset slave, await new start.
// - Acknowledged: hold clock until reload and release.
`timescale 1ns/10ps
module ists_top
  import ists_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Bus clock pin
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  // Bus data pin
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Software side
  input wire logic [6:0] OWN_ADDR,
  input wire logic BUF_WR,
  input wire logic [7:0] BUF_WDATA,
  input wire logic CTRL_WR,
  input wire logic [7:0] CTRL_WDATA,
  input wire logic IRQ_CLR,
  output logic [7:0] SERIAL_BUFFER_REG,
  output logic [7:0] SERIAL_PORT_CONTROL_REG,
  output logic [7:0] SERIAL_PORT_STATUS_REG,
  output logic SERIAL_PORT_IRQ_FLAG
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic scl_lvl;
  logic scl_rise;
  logic scl_fall;
  logic sda_lvl;
  logic sda_rise;
  logic sda_fall;

  ists_sync u_scl (.clk(SYS_CLK), .rst(RST), .async_in(SCL_IN), .level(scl_lvl), .rise(scl_rise), .fall(scl_fall));
  ists_sync u_sda (.clk(SYS_CLK), .rst(RST), .async_in(SDA_IN), .level(sda_lvl), .rise(sda_rise), .fall(sda_fall));

  // ****************************************
  // State
  // ****************************************
  ists_state_t state_r;
  ists_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [7:0] sr_r;
  logic [7:0] buf_r;
  logic [7:0] ctrl_r;
  logic [7:0] stat_r;
  logic irq_r;
  logic sda_low_r;
  logic scl_low_r;
  logic mack_r;

  wire start_det = sda_fall & scl_lvl;
  wire stop_det = sda_rise & scl_lvl;
  wire release_bit = ctrl_r[CTRL_RELEASE_BIT];
  wire [7:0] addr_byte = {sr_r[6:0], sda_lvl};
  wire addr_done = (state_r == ISTS_ADDR) && scl_rise && (cnt_r == BITS_PER_BYTE - 4'h1);
  wire read_match = addr_byte[7:1] == OWN_ADDR && addr_byte[0];
  // The acknowledge state spans the eighth fall (ack driven) and the ninth fall (ack released)
  wire ack_drive_fall = (state_r == ISTS_AACK) && scl_fall && (cnt_r == BITS_PER_BYTE);
  wire ack_end_fall = (state_r == ISTS_AACK) && scl_fall && (cnt_r == ACK_SLOT);
  wire ninth_fall = ack_end_fall || (scl_fall && state_r == ISTS_MACK);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ISTS_IDLE: begin
        state_nxt = ISTS_IDLE;
      end
      ISTS_ADDR: begin
        if (addr_done) begin
          state_nxt = read_match ? ISTS_AACK : ISTS_SKIP;
        end
      end
      ISTS_AACK: begin
        if (ack_end_fall) begin
          state_nxt = ISTS_HOLD;
        end
      end
      ISTS_HOLD: begin
        if (release_bit && !scl_lvl && scl_low_r == 1'b0) begin
          state_nxt = ISTS_SEND;
        end
      end
      ISTS_SEND: begin
        if (scl_fall && cnt_r == BITS_PER_BYTE - 4'h1) begin
          state_nxt = ISTS_MACK;
        end
      end
      ISTS_MACK: begin
        if (scl_fall) begin
          state_nxt = mack_r ? ISTS_IDLE : ISTS_HOLD;
        end
      end
      ISTS_SKIP: begin
        state_nxt = ISTS_SKIP;
      end
      default: begin
        state_nxt = ISTS_IDLE;
      end
    endcase
    if (start_det) begin
      state_nxt = ISTS_ADDR;
    end else if (stop_det) begin
      state_nxt = ISTS_IDLE;
    end
  end

  // ****************************************
  // Sequential logic
  // ****************************************
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_r <= ISTS_IDLE;
      cnt_r <= 4'h0;
      sr_r <= 8'h00;
      mack_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      if (start_det) begin
        cnt_r <= 4'h0;
      end else if (state_r == ISTS_ADDR && scl_rise) begin
        sr_r <= addr_byte;
        cnt_r <= cnt_r + 4'h1;
      end else if (state_r == ISTS_AACK && scl_rise) begin
        cnt_r <= ACK_SLOT;
      end else if (state_r == ISTS_SEND && scl_fall) begin
        sr_r <= {sr_r[6:0], 1'b1};
        cnt_r <= cnt_r + 4'h1;
      end else if (state_r == ISTS_HOLD) begin
        sr_r <= buf_r;
        cnt_r <= 4'h0;
      end
      if (state_r == ISTS_MACK && scl_rise) begin
        mack_r <= sda_lvl;
      end
    end
  end

  // Buffer: address byte on read match, otherwise software data
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      buf_r <= 8'h00;
    end else if (addr_done && read_match) begin
      buf_r <= addr_byte;
    end else if (BUF_WR) begin
      buf_r <= BUF_WDATA;
    end
  end

  // Hardware clearing of the release bit wins over a software write in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_r <= CTRL_RESET;
    end else if (ninth_fall && !(state_r == ISTS_MACK && mack_r)) begin
      ctrl_r[CTRL_RELEASE_BIT] <= 1'b0;
    end else if (CTRL_WR) begin
      ctrl_r <= CTRL_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      stat_r <= STAT_RESET;
    end else if (addr_done && read_match) begin
      stat_r[STAT_RW_BIT] <= 1'b1;
    end else if (state_r == ISTS_MACK && scl_fall && mack_r) begin
      stat_r <= STAT_RESET;
    end
  end

  // Set wins over a simultaneous software clear
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      irq_r <= 1'b0;
    end else if (ninth_fall) begin
      irq_r <= 1'b1;
    end else if (IRQ_CLR) begin
      irq_r <= 1'b0;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Clock is held from the ninth falling edge until software sets the release bit
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end else begin
      scl_low_r <= state_nxt == ISTS_HOLD && !(state_r == ISTS_HOLD && release_bit);
      // First data bit is set up while the clock is still held, so it never moves under a high clock
      if (state_nxt == ISTS_HOLD || (state_r == ISTS_HOLD && state_nxt == ISTS_SEND)) begin
        sda_low_r <= ~buf_r[7];
      end else if (ack_drive_fall) begin
        sda_low_r <= 1'b1;
      end else if (state_r == ISTS_SEND && scl_fall) begin
        sda_low_r <= (state_nxt == ISTS_SEND) ? ~sr_r[6] : 1'b0;
      end else if (state_nxt != ISTS_AACK && state_nxt != ISTS_SEND) begin
        sda_low_r <= 1'b0;
      end
    end
  end

  // the master waits on the held clock, so no timeout is kept here
  assign SCL_OUT = 1'b0;
  assign SCL_OE = scl_low_r;
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_low_r;
  assign SERIAL_BUFFER_REG = buf_r;
  assign SERIAL_PORT_CONTROL_REG = ctrl_r;
  assign SERIAL_PORT_STATUS_REG = stat_r;
  assign SERIAL_PORT_IRQ_FLAG = irq_r;
endmodule // ists_top

// ### ists_pkg.sv
// Package: constants and types of the two-wire slave transmit path
package ists_pkg;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_RELEASE_BIT = 4;
  localparam int STAT_RW_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h10;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [6:0] OWN_ADDR_RESET = 7'h42;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ISTS_IDLE  = 3'b000,
    ISTS_ADDR  = 3'b001,
    ISTS_AACK  = 3'b011,
    ISTS_HOLD  = 3'b010,
    ISTS_SEND  = 3'b110,
    ISTS_MACK  = 3'b111,
    ISTS_SKIP  = 3'b101
  } ists_state_t;
endpackage

// ### ists_sync.sv
// Two-flop synchroniser with edge detection taken from the second stage onward
`timescale 1ns/10ps
module ists_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous input and synchronised level and edges
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Reset to the idle-high bus level
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign level = s2_r;
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;
endmodule // ists_sync

// ### ists_assertions.sv
// Checker for the two-wire slave transmit path
`timescale 1ns/10ps
module ists_chk (
  // Clock and reset
  input logic SYS_CLK,
  input logic RST,
  // Bus pins
  input logic SCL_IN,
  input logic SCL_OE,
  input logic SDA_OE,
  // Software side
  input logic BUF_WR,
  input logic [7:0] BUF_WDATA,
  input logic CTRL_WR,
  input logic IRQ_CLR,
  input logic [7:0] SERIAL_BUFFER_REG,
  input logic [7:0] SERIAL_PORT_CONTROL_REG,
  input logic [7:0] SERIAL_PORT_STATUS_REG,
  input logic SERIAL_PORT_IRQ_FLAG
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  irq_sticky_a: assert property (SERIAL_PORT_IRQ_FLAG && !IRQ_CLR |=> SERIAL_PORT_IRQ_FLAG)
    else $error("irq flag lost");
  irq_fall_a: assert property ($rose(SERIAL_PORT_IRQ_FLAG) |-> !SCL_IN)
    else $error("irq set off a clock fall");
  clk_release_a: assert property ($rose(SERIAL_PORT_CONTROL_REG[4]) && SCL_OE |-> ##[1:3] !SCL_OE)
    else $error("clock not released");
  hold_keep_a: assert property (SCL_OE && !SERIAL_PORT_CONTROL_REG[4] && !CTRL_WR |=> SCL_OE)
    else $error("hold dropped early");
  hold_clear_a: assert property ($rose(SCL_OE) |-> ##[0:1] !SERIAL_PORT_CONTROL_REG[4])
    else $error("release bit kept");
  read_ack_a: assert property ($rose(SERIAL_PORT_STATUS_REG[2]) |-> ##[1:24] SDA_OE && !SCL_IN)
    else $error("no address ack");
  sda_steady_a: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE))
    else $error("data moved while clock high");
  nack_idle_a: assert property ($fell(SERIAL_PORT_STATUS_REG[2]) |-> !SCL_OE)
    else $error("held after reset");
  buf_load_a: assert property (BUF_WR |=> SERIAL_BUFFER_REG == $past(BUF_WDATA))
    else $error("buffer not loaded");
endmodule // ists_chk
bind ists_top ists_chk u_chk (.*);

// ### ists_master.sv
// Bus master model that reads from the slave
`timescale 1ns/10ps
module ists_master (
  // Wire levels
  input logic scl,
  input logic sda,
  // Master pull-downs
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 0;
    sda_low = 0;
  end
  task start;
    #80 sda_low = 1;
    #80 scl_low = 1;
    #40;
  endtask
  task stop;
    sda_low = 1;
    #80 scl_low = 0;
    #80 sda_low = 0;
    #80;
  endtask
  // Nine clocks, MSB first; data only moves while the clock is low
  task xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low = !tx[i];
      #40 scl_low = 0;
      wait (scl);
      // Step off the core clock's edges, since a stretched clock is released on one
      #1;
      #79 rx[i] = sda;
      scl_low = 1;
      #40;
    end
  endtask
endmodule // ists_master

// ### ists_tb.sv
// Testbench for the two-wire slave transmit path
`timescale 1ns/10ps
module testbench;
  import ists_pkg::*;
  logic SYS_CLK = 0, RST = 1, BUF_WR = 0, CTRL_WR = 0, IRQ_CLR = 0;
  logic [7:0] BUF_WDATA = 8'h00, CTRL_WDATA = 8'h00;
  logic [6:0] OWN_ADDR = OWN_ADDR_RESET;
  logic SCL_OE, SDA_OE, m_scl, m_sda, irq, scl_o, sda_o;
  logic [7:0] sbuf, sctl, sstat;
  int fail_count = 0, n_tests = 0;
  wire scl = !(SCL_OE | m_scl);
  wire sda = !(SDA_OE | m_sda);
  always #5 SYS_CLK = !SYS_CLK;
  ists_top u_dut (.SYS_CLK(SYS_CLK), .RST(RST), .SCL_IN(scl), .SCL_OUT(scl_o), .SCL_OE(SCL_OE),
    .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE(SDA_OE), .OWN_ADDR(OWN_ADDR), .BUF_WR(BUF_WR),
    .BUF_WDATA(BUF_WDATA), .CTRL_WR(CTRL_WR), .CTRL_WDATA(CTRL_WDATA), .IRQ_CLR(IRQ_CLR),
    .SERIAL_BUFFER_REG(sbuf), .SERIAL_PORT_CONTROL_REG(sctl),
    .SERIAL_PORT_STATUS_REG(sstat), .SERIAL_PORT_IRQ_FLAG(irq));
  ists_master u_m (.scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task sw(input logic bw, input logic cw, input logic ic, input logic [7:0] d);
    @(negedge SYS_CLK);
    BUF_WR = bw;
    CTRL_WR = cw;
    IRQ_CLR = ic;
    BUF_WDATA = d;
    CTRL_WDATA = d;
    @(negedge SYS_CLK);
    {BUF_WR, CTRL_WR, IRQ_CLR} = 3'b000;
  endtask
  // Write direction and a foreign address must both be ignored
  task t_ignore;
    logic [8:0] rx;
    for (int i = 0; i < 2; i++) begin
      u_m.start;
      u_m.xfer({OWN_ADDR ^ 7'(i), i[0], 1'b1}, rx);
      chk({rx[0], sstat, irq, SCL_OE}, {1'b1, STAT_RESET, 2'b00});
      u_m.stop;
    end
  endtask
  // Three bytes, the last one refused; software reloads while the master is stalled
  task t_read;
    logic [8:0] rx;
    logic [7:0] d;
    u_m.start;
    u_m.xfer({OWN_ADDR, 2'b11}, rx);
    chk(rx[0], 0);
    chk({sstat[STAT_RW_BIT], sbuf}, {1'b1, OWN_ADDR, 1'b1});
    for (int i = 0; i < 3; i++) begin
      d = 8'ha5 ^ (8'h3c << i);
      fork
        u_m.xfer({8'hff, i == 2}, rx);
        begin
          repeat (40) @(negedge SYS_CLK);
          chk({SCL_OE, sctl[CTRL_RELEASE_BIT], irq}, 3'b101);
          sw(0, 0, 1, 8'h00);
          sw(1, 0, 0, d);
          sw(0, 1, 0, CTRL_RESET);
        end
      join
      chk(rx[8:1], d);
    end
    repeat (8) @(negedge SYS_CLK);
    chk({irq, sstat, SCL_OE}, {1'b1, STAT_RESET, 1'b0});
    u_m.stop;
    sw(0, 0, 1, 8'h00);
  endtask
  initial begin
    repeat (16) @(negedge SYS_CLK);
    RST = 0;
    repeat (4) @(negedge SYS_CLK);
    chk({sctl, sstat, irq}, {CTRL_RESET, STAT_RESET, 1'b0});
    chk({scl_o, sda_o, SCL_OE, SDA_OE}, 4'h0);
    t_ignore;
    t_read;
    t_read;
    complete_run;
  end
  initial begin
    #200000;
    fail_count++;
    complete_run;
  end
endmodule // testbench
